//--- src/ccp_defines.vh
`ifndef CCP_DEFINES_VH
`define CCP_DEFINES_VH

// ----------------------------------------
// Data-space addresses
// ----------------------------------------
`define CCP_ADDR_INDIRECT 5'h00
`define CCP_ADDR_PCL      5'h02
`define CCP_ADDR_STATUS   5'h03
`define CCP_ADDR_FSR      5'h04

// ----------------------------------------
// Status fields and reset values
// ----------------------------------------
`define CCP_ST_C          0
`define CCP_ST_HC         1
`define CCP_ST_Z          2
`define CCP_STATUS_RESET  8'h18
`define CCP_FSR_RESET     8'h00
`define CCP_W_RESET       8'h00
`define CCP_PC_RESET      10'h000
`define CCP_INSTR_RESET   12'h000

// ----------------------------------------
// Instruction fields
// ----------------------------------------
`define CCP_OP_HI         11
`define CCP_OP_LO         8
`define CCP_DEST_BIT      5
`define CCP_GOTO_PREFIX   2'h3
`define CCP_OP_ADD        4'h0
`define CCP_OP_SUB        4'h1
`define CCP_OP_AND        4'h2
`define CCP_OP_IOR        4'h3
`define CCP_OP_XOR        4'h4
`define CCP_OP_RRF        4'h5
`define CCP_OP_RLF        4'h6
`define CCP_OP_MOVF       4'h7
`define CCP_OP_MOVWF      4'h8
`define CCP_OP_CLR        4'h9
`define CCP_OP_MOVLW      4'hA
`define CCP_OP_ANDLW      4'hB

// ----------------------------------------
// Oscillator modes and timing
// ----------------------------------------
`define CCP_OSC_SLOW      3'h0
`define CCP_OSC_XTAL      3'h1
`define CCP_OSC_HS        3'h2
`define CCP_OSC_RC_EXT    3'h3
`define CCP_OSC_RC_INT    3'h4
`define CCP_PHASES        4
`define CCP_CYCLE_NS_MAX  200
`define CCP_FEATURE_MASK  6'h1B

`endif

//--- src/ccp_phase_gen.v
// ----------------------------------------
// Four non-overlapping phases, one clock each
// ----------------------------------------
module ccp_phase_gen (
    input  wire clock,
    input  wire rst_n,
    output reg  phase_one,
    output reg  phase_two,
    output reg  phase_three,
    output reg  phase_four
);
    always @(posedge clock) begin
        if (!rst_n) begin
            phase_one   <= 1'b1;
            phase_two   <= 1'b0;
            phase_three <= 1'b0;
            phase_four  <= 1'b0;
        end else begin
            phase_one   <= phase_four;
            phase_two   <= phase_one;
            phase_three <= phase_two;
            phase_four  <= phase_three;
        end
    end
endmodule

//--- src/ccp_alu.v
`include "ccp_defines.vh"

// ----------------------------------------
// 8-bit arithmetic unit with flag results
// ----------------------------------------
module ccp_alu (
    input  wire [11:0] instr,
    input  wire [7:0]  fval,
    input  wire [7:0]  wval,
    input  wire        carry_in,
    output reg  [7:0]  result,
    output reg         c_out,
    output reg         hc_out,
    output wire        z_out,
    output reg         upd_c,
    output reg         upd_hc,
    output reg         upd_z
);
    reg [3:0] op;
    reg [7:0] b;
    reg [8:0] sum9;
    reg [4:0] nib5;
    reg       cin;

    assign z_out = (result == 8'h00);

    always @* begin
        op     = instr[`CCP_OP_HI:`CCP_OP_LO];
        // Subtract as f + ~w + 1 so carry reads as no-borrow
        cin    = (op == `CCP_OP_SUB);
        b      = cin ? ~wval : wval;
        sum9   = {1'b0, fval} + {1'b0, b} + {8'h00, cin};
        nib5   = {1'b0, fval[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        result = 8'h00;
        c_out  = sum9[8];
        hc_out = nib5[4];
        upd_c  = 1'b0;
        upd_hc = 1'b0;
        upd_z  = 1'b0;
        case (op)
            `CCP_OP_ADD, `CCP_OP_SUB: begin
                result = sum9[7:0];
                upd_c  = 1'b1;
                upd_hc = 1'b1;
                upd_z  = 1'b1;
            end
            `CCP_OP_AND: begin
                result = fval & wval;
                upd_z  = 1'b1;
            end
            `CCP_OP_IOR: begin
                result = fval | wval;
                upd_z  = 1'b1;
            end
            `CCP_OP_XOR: begin
                result = fval ^ wval;
                upd_z  = 1'b1;
            end
            `CCP_OP_RRF: begin
                result = {carry_in, fval[7:1]};
                c_out  = fval[0];
                upd_c  = 1'b1;
            end
            `CCP_OP_RLF: begin
                result = {fval[6:0], carry_in};
                c_out  = fval[7];
                upd_c  = 1'b1;
            end
            `CCP_OP_MOVF: begin
                result = fval;
                upd_z  = 1'b1;
            end
            `CCP_OP_MOVWF: begin
                result = wval;
            end
            `CCP_OP_CLR: begin
                result = 8'h00;
                upd_z  = 1'b1;
            end
            `CCP_OP_MOVLW: begin
                result = instr[7:0];
            end
            `CCP_OP_ANDLW: begin
                result = instr[7:0] & wval;
                upd_z  = 1'b1;
            end
            default: begin
                result = 8'h00;
            end
        endcase
    end
endmodule

//--- src/ccp_core.v
`include "ccp_defines.vh"

module ccp_core (
    input  wire        clock,
    input  wire        nrst,
    input  wire [2:0]  osc_mode,
    input  wire        reset_pin_en,
    input  wire        rate_out_en,
    input  wire        timer_clk_select,
    input  wire [5:0]  pullup_req,
    input  wire [5:0]  wake_req,
    output wire [9:0]  prog_addr,
    input  wire [11:0] prog_data,
    output reg  [4:0]  file_addr,
    output reg         file_re,
    output reg         file_we,
    output reg  [7:0]  file_wdata,
    input  wire [7:0]  file_rdata,
    input  wire [5:0]  port_b_in,
    input  wire [5:0]  port_b_drive,
    input  wire [5:0]  port_b_dir,
    output reg  [5:0]  port_b_out,
    output reg  [5:0]  port_b_oe,
    output reg  [5:0]  port_b_pullup,
    input  wire        port_c5_in,
    input  wire        port_c5_drive,
    input  wire        port_c5_dir,
    output reg         port_c5_out,
    output reg         port_c5_oe,
    output reg         xtal_in_is_clock,
    output reg         xtal_out_is_crystal,
    output reg         timer_ext_clk_in,
    output reg         wake_event,
    output wire        core_reset,
    output wire [7:0]  w_value,
    output wire [7:0]  status_value,
    output wire        phase_one,
    output wire        phase_two,
    output wire        phase_three,
    output wire        phase_four
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    reg  [5:0] b_meta;
    reg  [5:0] b_sync;
    reg  [5:0] b_prev;
    reg        c5_meta;
    reg        c5_sync;

    always @(posedge clock) begin
        if (!nrst) begin
            b_meta  <= 6'h3F;
            b_sync  <= 6'h3F;
            b_prev  <= 6'h3F;
            c5_meta <= 1'b0;
            c5_sync <= 1'b0;
        end else begin
            b_meta  <= port_b_in;
            b_sync  <= b_meta;
            b_prev  <= b_sync;
            c5_meta <= port_c5_in;
            c5_sync <= c5_meta;
        end
    end

    // ----------------------------------------
    // Reset and phases
    // ----------------------------------------
    wire master_clear_n = b_sync[3];
    wire core_rst_n     = nrst & ~(reset_pin_en & ~master_clear_n);

    assign core_reset = ~core_rst_n;

    ccp_phase_gen u_phase (
        .clock       (clock),
        .rst_n       (core_rst_n),
        .phase_one   (phase_one),
        .phase_two   (phase_two),
        .phase_three (phase_three),
        .phase_four  (phase_four)
    );

    // ----------------------------------------
    // Pipeline state
    // ----------------------------------------
    reg  [9:0]  pc;
    reg         hold;
    reg         flush;
    reg  [11:0] instr_latch;
    reg  [7:0]  w;
    reg  [7:0]  status;
    reg  [7:0]  fsr;
    reg  [7:0]  operand;

    // Accumulator is private: nothing in the address decode reaches it
    assign w_value      = w;
    assign status_value = status;
    assign prog_addr    = pc;

    wire [3:0] op        = instr_latch[`CCP_OP_HI:`CCP_OP_LO];
    wire       is_goto   = (instr_latch[11:10] == `CCP_GOTO_PREFIX);
    wire       is_imm    = (op == `CCP_OP_MOVLW) | (op == `CCP_OP_ANDLW);
    wire       uses_file = ~is_goto & ~is_imm;
    wire       exec_ok   = ~flush;
    wire [4:0] f_field   = instr_latch[4:0];
    wire [4:0] eff_addr  = (f_field == `CCP_ADDR_INDIRECT) ?
                           fsr[4:0] : f_field;
    wire       at_pcl    = (eff_addr == `CCP_ADDR_PCL);
    wire       at_status = (eff_addr == `CCP_ADDR_STATUS);
    wire       at_fsr    = (eff_addr == `CCP_ADDR_FSR);
    wire       at_ind    = (eff_addr == `CCP_ADDR_INDIRECT);
    wire       internal  = at_pcl | at_status | at_fsr | at_ind;

    // Destination: file for MOVWF, by d bit for file ops and CLR
    wire d_bit  = instr_latch[`CCP_DEST_BIT];
    wire dest_f = uses_file &
                  ((op == `CCP_OP_MOVWF) | d_bit);
    wire dest_w = ~is_goto & ~dest_f;

    // Reads of PCL give the address already being fetched
    reg [7:0] read_mux;
    always @* begin
        if (at_pcl)
            read_mux = pc[7:0];
        else if (at_status)
            read_mux = status;
        else if (at_fsr)
            read_mux = fsr;
        else if (at_ind)
            read_mux = 8'h00;
        else
            read_mux = file_rdata;
    end

    wire [7:0] alu_res;
    wire       alu_c;
    wire       alu_hc;
    wire       alu_z;
    wire       upd_c;
    wire       upd_hc;
    wire       upd_z;

    ccp_alu u_alu (
        .instr    (instr_latch),
        .fval     (operand),
        .wval     (w),
        .carry_in (status[`CCP_ST_C]),
        .result   (alu_res),
        .c_out    (alu_c),
        .hc_out   (alu_hc),
        .z_out    (alu_z),
        .upd_c    (upd_c),
        .upd_hc   (upd_hc),
        .upd_z    (upd_z)
    );

    wire branch = exec_ok & (is_goto | (dest_f & at_pcl));

    // Flag updates override a direct write to the same bits;
    // the two power-state bits are read-only.
    reg [7:0] next_status;
    always @* begin
        next_status = status;
        if (dest_f & at_status)
            next_status = {alu_res[7:5], status[4:3], alu_res[2:0]};
        if (upd_c)
            next_status[`CCP_ST_C] = alu_c;
        if (upd_hc)
            next_status[`CCP_ST_HC] = alu_hc;
        if (upd_z)
            next_status[`CCP_ST_Z] = alu_z;
    end

    // ----------------------------------------
    // Phase sequencing
    // ----------------------------------------
    always @(posedge clock) begin
        if (!core_rst_n) begin
            pc          <= `CCP_PC_RESET;
            hold        <= 1'b1;
            flush       <= 1'b1;
            instr_latch <= `CCP_INSTR_RESET;
            w           <= `CCP_W_RESET;
            status      <= `CCP_STATUS_RESET;
            fsr         <= `CCP_FSR_RESET;
            operand     <= 8'h00;
            file_addr   <= 5'h00;
            file_re     <= 1'b0;
            file_we     <= 1'b0;
            file_wdata  <= 8'h00;
        end else begin
            if (phase_one) begin
                // Held once after a load so the target itself is fetched
                if (!hold)
                    pc <= pc + 10'h001;
                hold      <= 1'b0;
                file_addr <= eff_addr;
                file_re   <= exec_ok & uses_file & ~internal;
            end
            if (phase_two) begin
                file_re <= 1'b0;
                operand <= read_mux;
            end
            if (phase_three) begin
                file_wdata <= alu_res;
                file_we    <= exec_ok & dest_f & ~internal;
            end
            if (phase_four) begin
                file_we     <= 1'b0;
                instr_latch <= prog_data;
                flush       <= branch;
                if (exec_ok) begin
                    if (dest_w)
                        w <= alu_res;
                    status <= next_status;
                    if (dest_f & at_fsr)
                        fsr <= alu_res;
                    if (is_goto) begin
                        pc   <= instr_latch[9:0];
                        hold <= 1'b1;
                    end else if (dest_f & at_pcl) begin
                        pc   <= {2'b00, alu_res};
                        hold <= 1'b1;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Shared pin functions
    // ----------------------------------------
    wire xtal_mode = (osc_mode == `CCP_OSC_XTAL) |
                     (osc_mode == `CCP_OSC_SLOW);
    wire rc_mode   = (osc_mode == `CCP_OSC_RC_EXT) |
                     (osc_mode == `CCP_OSC_RC_INT);
    wire int_rc    = (osc_mode == `CCP_OSC_RC_INT);
    wire rate_on   = rc_mode & rate_out_en;
    wire cycle_rate_out = phase_three | phase_four;

    // Pins taken by other functions, except bit 4 as rate output, neither pull up nor wake
    wire [5:0] feat_mask = `CCP_FEATURE_MASK &
                           {1'b1, ~xtal_mode, ~reset_pin_en, 3'h7};
    wire [5:0] change    = (b_sync ^ b_prev) & wake_req & feat_mask;

    reg [5:0] next_b_out;
    reg [5:0] next_b_oe;
    always @* begin
        next_b_out = port_b_drive;
        next_b_oe  = port_b_dir;
        next_b_oe[3] = 1'b0;
        if (xtal_mode)
            next_b_oe[4] = 1'b0;
        else if (rate_on) begin
            next_b_out[4] = cycle_rate_out;
            next_b_oe[4]  = 1'b1;
        end
        if (!int_rc)
            next_b_oe[5] = 1'b0;
    end

    always @(posedge clock) begin
        if (!nrst) begin
            port_b_out          <= 6'h00;
            port_b_oe           <= 6'h00;
            port_b_pullup       <= 6'h00;
            port_c5_out         <= 1'b0;
            port_c5_oe          <= 1'b0;
            xtal_in_is_clock    <= 1'b1;
            xtal_out_is_crystal <= 1'b0;
            timer_ext_clk_in    <= 1'b0;
            wake_event          <= 1'b0;
        end else begin
            port_b_out          <= next_b_out;
            port_b_oe           <= next_b_oe;
            port_b_pullup       <= pullup_req & feat_mask;
            port_c5_out         <= port_c5_drive;
            port_c5_oe          <= port_c5_dir & ~timer_clk_select;
            xtal_in_is_clock    <= ~int_rc;
            xtal_out_is_crystal <= xtal_mode;
            timer_ext_clk_in    <= timer_clk_select & c5_sync;
            wake_event          <= |change;
        end
    end
endmodule

//--- testbench/ccp_core_chk.sv
`include "ccp_defines.vh"

module ccp_core_chk (
    input wire       clock,
    input wire       nrst,
    input wire [2:0] osc_mode,
    input wire       reset_pin_en,
    input wire       timer_clk_select,
    input wire [5:0] port_b_in,
    input wire [9:0] prog_addr,
    input wire [4:0] file_addr,
    input wire       file_re,
    input wire       file_we,
    input wire [5:0] port_b_pullup,
    input wire       xtal_in_is_clock,
    input wire       xtal_out_is_crystal,
    input wire       timer_ext_clk_in,
    input wire       core_reset,
    input wire       phase_one,
    input wire       phase_two,
    input wire       phase_three,
    input wire       phase_four
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (core_reset);

    property p_phase_onehot;
        $onehot({phase_one, phase_two, phase_three, phase_four});
    endproperty
    a_phase_onehot: assert property (p_phase_onehot)
        else $error("phases not one-hot");
    property p_phase_order;
        phase_one |=> phase_two ##1 phase_three ##1 phase_four ##1 phase_one;
    endproperty
    a_phase_order: assert property (p_phase_order)
        else $error("phase order broken");
    property p_fetch_hold;
        phase_two |=> $stable(prog_addr) [*2];
    endproperty
    a_fetch_hold: assert property (p_fetch_hold)
        else $error("fetch address moved mid cycle");
    property p_read_slot;
        file_re |-> phase_two;
    endproperty
    a_read_slot: assert property (p_read_slot)
        else $error("read strobe outside phase two");
    property p_write_slot;
        file_we |-> phase_four && !file_re;
    endproperty
    a_write_slot: assert property (p_write_slot)
        else $error("write strobe outside phase four");
    property p_addr_hold;
        phase_two |=> $stable(file_addr) [*3];
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("file address moved mid cycle");
    property p_crystal;
        $past(nrst) |-> xtal_out_is_crystal ==
            ($past(osc_mode) == `CCP_OSC_XTAL
            || $past(osc_mode) == `CCP_OSC_SLOW);
    endproperty
    a_crystal: assert property (p_crystal)
        else $error("crystal output select wrong");
    property p_clock_in;
        $past(nrst) |->
            xtal_in_is_clock == ($past(osc_mode) != `CCP_OSC_RC_INT);
    endproperty
    a_clock_in: assert property (p_clock_in)
        else $error("clock input select wrong");
    property p_timer_gate;
        $past(nrst) && !$past(timer_clk_select) |-> !timer_ext_clk_in;
    endproperty
    a_timer_gate: assert property (p_timer_gate)
        else $error("timer clock passed while not selected");
    property p_pullup_mask;
        $past(nrst) |-> !port_b_pullup[2] && !port_b_pullup[5]
            && !($past(reset_pin_en) && port_b_pullup[3]);
    endproperty
    a_pullup_mask: assert property (p_pullup_mask)
        else $error("pull-up on unsupported bit");
    property p_master_clear;
        disable iff (!nrst)
            reset_pin_en && !port_b_in[3] |-> ##[1:3] core_reset;
    endproperty
    a_master_clear: assert property (p_master_clear)
        else $error("master clear ignored");
endmodule

bind ccp_core ccp_core_chk chk_u (
    .clock(clock), .nrst(nrst), .osc_mode(osc_mode),
    .reset_pin_en(reset_pin_en), .timer_clk_select(timer_clk_select),
    .port_b_in(port_b_in), .prog_addr(prog_addr), .file_addr(file_addr),
    .file_re(file_re), .file_we(file_we), .port_b_pullup(port_b_pullup),
    .xtal_in_is_clock(xtal_in_is_clock),
    .xtal_out_is_crystal(xtal_out_is_crystal),
    .timer_ext_clk_in(timer_ext_clk_in), .core_reset(core_reset),
    .phase_one(phase_one), .phase_two(phase_two),
    .phase_three(phase_three), .phase_four(phase_four)
);

//--- testbench/ccp_mem_model.sv
module ccp_mem_model (
    input  wire        clock,
    input  wire [9:0]  prog_addr,
    output logic [11:0] prog_data,
    input  wire [4:0]  file_addr,
    input  wire        file_re,
    input  wire        file_we,
    input  wire [7:0]  file_wdata,
    output logic [7:0] file_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [11:0] mem [0:1023];
    logic [7:0]  rf [0:31];
    logic [7:0]  last;

    initial begin
        last = 8'h00;
        for (int i = 0; i < 1024; i++) mem[i] = 12'h000;
        for (int i = 0; i < 32; i++) rf[i] = 8'h00;
    end
    // Whole word on its own bus
    assign prog_data = mem[prog_addr];
    // Not selected: show the inverse so stale data never looks valid
    assign file_rdata = file_re ? rf[file_addr] : ~last;
    always @(posedge clock) begin
        if (file_re)
            last <= rf[file_addr];
        if (file_we)
            rf[file_addr] <= file_wdata;
    end
endmodule

//--- testbench/test_cpu_core_clocking_pipeline.sv
module test_cpu_core_clocking_pipeline;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, nrst, reset_pin_en, rate_out_en, timer_clk_select;
    logic port_c5_in, port_c5_drive, port_c5_dir;
    logic [2:0] osc_mode;
    logic [5:0] pullup_req, wake_req, port_b_in, port_b_drive, port_b_dir;
    logic [9:0] prog_addr;
    logic [11:0] prog_data;
    logic [4:0] file_addr;
    logic file_re, file_we, port_c5_out, port_c5_oe, xtal_in_is_clock;
    logic xtal_out_is_crystal, timer_ext_clk_in, wake_event, core_reset;
    logic phase_one, phase_two, phase_three, phase_four;
    logic [7:0] file_wdata, file_rdata, w_value, status_value;
    logic [5:0] port_b_out, port_b_oe, port_b_pullup;
    int errors, num_checks;

    ccp_core dut_u (
        .clock(clock), .nrst(nrst), .osc_mode(osc_mode),
        .reset_pin_en(reset_pin_en), .rate_out_en(rate_out_en),
        .timer_clk_select(timer_clk_select), .pullup_req(pullup_req),
        .wake_req(wake_req), .prog_addr(prog_addr), .prog_data(prog_data),
        .file_addr(file_addr), .file_re(file_re), .file_we(file_we),
        .file_wdata(file_wdata), .file_rdata(file_rdata),
        .port_b_in(port_b_in), .port_b_drive(port_b_drive),
        .port_b_dir(port_b_dir), .port_b_out(port_b_out),
        .port_b_oe(port_b_oe), .port_b_pullup(port_b_pullup),
        .port_c5_in(port_c5_in), .port_c5_drive(port_c5_drive),
        .port_c5_dir(port_c5_dir), .port_c5_out(port_c5_out),
        .port_c5_oe(port_c5_oe), .xtal_in_is_clock(xtal_in_is_clock),
        .xtal_out_is_crystal(xtal_out_is_crystal),
        .timer_ext_clk_in(timer_ext_clk_in), .wake_event(wake_event),
        .core_reset(core_reset), .w_value(w_value),
        .status_value(status_value), .phase_one(phase_one),
        .phase_two(phase_two), .phase_three(phase_three),
        .phase_four(phase_four)
    );
    ccp_mem_model mdl_u (
        .clock(clock), .prog_addr(prog_addr), .prog_data(prog_data),
        .file_addr(file_addr), .file_re(file_re), .file_we(file_we),
        .file_wdata(file_wdata), .file_rdata(file_rdata)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Reads here see the values settled before the edge
    task tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task do_reset;
        @(posedge clock);
        nrst <= 1'b0;
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
    endtask
    // Counts instruction cycles until the write to wa is seen
    task run(input logic [71:0] prog, input logic [4:0] wa, output int cyc);
        int n;
        for (int i = 0; i < 6; i++) mdl_u.mem[i] = prog[71-12*i -: 12];
        do_reset;
        cyc = 0;
        n = 0;
        while (n < 200 && !(file_we === 1'b1 && file_addr === wa)) begin
            tick(1);
            cyc += (phase_four === 1'b1);
            n++;
        end
        check(n < 200, 1'b1);
        tick(12);
    endtask
    task alu_case(input logic [3:0] op, input logic [7:0] f, w, res, st);
        int c;
        run({4'hA, f, 12'h810, 4'hA, w, op, 8'h10, 24'hC04_C05}, 5'h10, c);
        check(c, 3);
        check(w_value, res);
        check(status_value, st);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_alu;
        alu_case(4'h0, 8'h0F, 8'h01, 8'h10, 8'h1A);
        alu_case(4'h0, 8'hF0, 8'h10, 8'h00, 8'h1D);
        alu_case(4'h1, 8'h01, 8'h02, 8'hFF, 8'h18);
        alu_case(4'h1, 8'h05, 8'h05, 8'h00, 8'h1F);
        alu_case(4'h2, 8'hF0, 8'h3C, 8'h30, 8'h18);
        alu_case(4'h3, 8'h00, 8'h00, 8'h00, 8'h1C);
        alu_case(4'h4, 8'hAA, 8'hAA, 8'h00, 8'h1C);
        alu_case(4'h5, 8'h81, 8'h00, 8'h40, 8'h19);
        alu_case(4'h6, 8'h81, 8'h00, 8'h02, 8'h19);
        alu_case(4'h7, 8'h00, 8'h00, 8'h00, 8'h1C);
        alu_case(4'hB, 8'hFF, 8'h0F, 8'h00, 8'h1C);
    endtask
    task t_flow;
        int c;
        run(72'hA55_810_900_811_930_C05, 5'h11, c);
        check(c, 5);
        check(mdl_u.rf[5'h10], 8'h00);
        check(w_value, 8'h00);
        run(72'hA15_804_A77_800_C04_C05, 5'h15, c);
        check(mdl_u.rf[5'h15], 8'h77);
        mdl_u.rf[5'h13] = 8'hEE;
        run(72'hA04_802_A33_813_814_C05, 5'h14, c);
        check(c, 5);
        check(mdl_u.rf[5'h13], 8'hEE);
        run(72'hA11_C04_A22_A33_812_C05, 5'h12, c);
        check(c, 5);
        check(mdl_u.rf[5'h12], 8'h11);
    endtask
    task t_master_clear;
        @(posedge clock);
        reset_pin_en <= 1'b1;
        port_b_in <= 6'h37;
        tick(6);
        check(core_reset, 1'b1);
        check(w_value, 8'h00);
        port_b_in <= 6'h3F;
        tick(6);
        check(core_reset, 1'b0);
        reset_pin_en <= 1'b0;
        port_b_in <= 6'h37;
        tick(6);
        check(core_reset, 1'b0);
        port_b_in <= 6'h3F;
    endtask
    task t_pins;
        int n;
        port_b_dir <= 6'h3F;
        port_b_drive <= 6'h3F;
        pullup_req <= 6'h3F;
        rate_out_en <= 1'b1;
        for (int m = 0; m < 5; m++) begin
            osc_mode <= m[2:0];
            tick(4);
            check(xtal_out_is_crystal, m < 2);
            check(xtal_in_is_clock, m != 4);
            check(port_b_oe[5:3], {m == 4, m >= 2, 1'b0});
            check(port_b_pullup, (m < 2) ? 6'h0B : 6'h1B);
            n = 0;
            repeat (8) begin
                tick(1);
                n += (port_b_out[4] === 1'b1);
            end
            if (m >= 2)
                check(n, (m == 2) ? 8 : 4);
        end
        reset_pin_en <= 1'b1;
        tick(4);
        check(port_b_pullup, 6'h13);
        reset_pin_en <= 1'b0;
    endtask
    task t_timer_wake;
        int n;
        port_c5_in <= 1'b1;
        port_c5_dir <= 1'b1;
        port_c5_drive <= 1'b1;
        tick(5);
        check(timer_ext_clk_in, 1'b0);
        check(port_c5_oe, 1'b1);
        check(port_c5_out, 1'b1);
        timer_clk_select <= 1'b1;
        tick(5);
        check(timer_ext_clk_in, 1'b1);
        check(port_c5_oe, 1'b0);
        port_c5_in <= 1'b0;
        tick(5);
        check(timer_ext_clk_in, 1'b0);
        wake_req <= 6'h01;
        tick(4);
        port_b_in <= 6'h3E;
        n = 0;
        repeat (6) begin
            tick(1);
            n += (wake_event === 1'b1);
        end
        check(n, 1);
        wake_req <= 6'h04;
        tick(4);
        port_b_in <= 6'h3A;
        n = 0;
        repeat (6) begin
            tick(1);
            n += (wake_event === 1'b1);
        end
        check(n, 0);
    endtask

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        #80000;
        errors++;
        $display("ERROR %0t: watchdog expired", $time);
        print_verdict;
    end
    initial begin
        errors = 0;
        num_checks = 0;
        nrst = 1'b0;
        osc_mode = 3'h2;
        {reset_pin_en, rate_out_en, timer_clk_select} = 3'b000;
        {port_c5_in, port_c5_drive, port_c5_dir} = 3'b000;
        {pullup_req, wake_req, port_b_drive, port_b_dir} = 24'h0000_00;
        port_b_in = 6'h3F;
        t_alu;
        t_flow;
        t_master_clear;
        t_pins;
        t_timer_wake;
        print_verdict;
    end
endmodule
